// >>> rtl/amp_control_diag_serial_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: A fault is reported only if it held through the whole measurement period.
// R2: Every read re-arms all diagnostic cycle types for continuous diagnostics.
// R3: A read returns results of the cycle completed before it.
// R4: Host needs two reads to see a change in fault status.
// R5: Three thermal warnings appear in the diagnostic data.
// R6: Fast-mute bit set gives a mute transition under 1.5 ms.
// R7: Host clears the fast-mute bit shortly after the mute transition.
// R8: Efficiency mode closes bridge switch below 2.5 W, opens it above.
// R9: Channels one/two share one switch, three/four share another.
// R10: Efficiency mode is suspended at low supply and resumes by itself.
// R11: Silent turn-on: wait 10 ms, standby off with diagnostics, 1 s, unmute.
// R12: Silent turn-off: mute, wait 50 ms, then hardware standby.
// R13: Installation: enable diagnostics, wait 200 ms, read until faults clear.
// R14: Offset test: play silent, enable offset, 30 ms, read until flag clears.
// R15: Open address strap disables the bus; standby/mute pin controls the device.
// R16: Bus disabled: clock pin selects efficiency, data pin selects gain.
// R17: Seven-bit address follows the strap resistor range.
// R18: Data changes only while clock is low.
// R19: Start is data falling with clock high; stop is data rising.
// R20: Each byte is eight bits, MSB first, then one acknowledge bit.
// R21: Receiver pulls data low during the acknowledge clock pulse.
// R22: Address LSB zero writes instruction bytes, one reads diagnostic bytes.
// R23: A mismatched address is not acknowledged and the transfer is ignored.
module amp_control_diag_serial_port #(
  parameter int FAST_MUTE_CYCLES   = amp_pkg::FAST_MUTE_CYC,
  parameter int NORMAL_MUTE_CYCLES = amp_pkg::NORMAL_MUTE_CYC
) (
  // System clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_n_in,
  // Serial bus, clock is the link domain
  input  wire logic                         scl_in,
  input  wire logic                         sda_in,
  output logic                              sda_out,
  output logic                              sda_oe_n_out,
  // Straps and pins
  input  wire logic [1:0]                   address_strap_pin_in,
  input  wire logic                         standby_mute_pin_in,
  // Analog sense inputs
  input  wire logic [amp_pkg::FAULT_W-1:0]  fault_in,
  input  wire logic [2:0]                   thermal_warn_in,
  input  wire logic [1:0]                   power_above_in,
  input  wire logic                         supply_low_in,
  // Amplifier controls
  output logic                              standby_out,
  output logic [1:0]                        unmute_out,
  output logic [1:0]                        gain_low_out,
  output logic                              diag_enable_out,
  output logic                              offset_enable_out,
  output logic                              muted_out,
  output logic [1:0]                        bridge_close_out,
  output logic                              bus_disabled_out
);
  logic [7:0]                     ib1_q, ib2_q;
  logic [6:0]                     own_addr_q;
  logic                           bus_en_q, strap_done_q;
  logic [amp_pkg::DIAG_W-1:0]     diag_word, diag_raw;
  logic                           read_close;
  // Link side state
  logic                           start_tgl_q, stop_tgl_q, start_seen_q;
  amp_pkg::link_state_e           st_q;
  logic [3:0]                     cnt_q;
  logic [7:0]                     shift_q, wr_ib1_q, wr_ib2_q, rd_byte;
  logic                           byte_idx_q, wr_tgl_q, rd_tgl_q;
  logic [1:0]                     rd_idx_q;
  // Synchronisers into the system clock
  logic [1:0]                     wr_sync_q, rd_sync_q, busy_sync_q;
  logic [1:0]                     scl_sync_q, sda_sync_q, pin_sync_q, low_sync_q;
  logic [1:0]                     pw0_sync_q, pw1_sync_q;
  logic [3:0]                     strap_sync_q;
  logic                           wr_seen_q, rd_seen_q, rd_pend_q, mute_req;
  logic [amp_pkg::DIAG_W-1:0]     diag_s1_q, diag_s2_q;
  logic [amp_pkg::MUTE_CNT_W-1:0] mute_cnt_q;
  // Start and stop seen on data edges while the clock is high
  always_ff @(negedge sda_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_tgl_q <= 1'b0;
    end else if (scl_in) begin
      start_tgl_q <= ~start_tgl_q;                  // see R19
    end
  end
  always_ff @(posedge sda_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_tgl_q <= 1'b0;
    end else if (scl_in) begin
      stop_tgl_q <= ~stop_tgl_q;                    // see R19
    end
  end
  // Byte engine, samples on rising clock
  always_ff @(posedge scl_in) begin
    if (!rst_n_in) begin
      st_q         <= amp_pkg::LNK_IDLE;
      cnt_q        <= 4'h0;
      shift_q      <= 8'h00;
      start_seen_q <= 1'b0;
      byte_idx_q   <= 1'b0;
      rd_idx_q     <= 2'h0;
      wr_ib1_q     <= amp_pkg::IB1_RESET;
      wr_ib2_q     <= amp_pkg::IB2_RESET;
      wr_tgl_q     <= 1'b0;
      rd_tgl_q     <= 1'b0;
    end else if (start_tgl_q != start_seen_q) begin
      start_seen_q <= start_tgl_q;
      shift_q      <= {7'h00, sda_in};
      cnt_q        <= 4'h1;
      st_q         <= bus_en_q ? amp_pkg::LNK_ADDR : amp_pkg::LNK_IDLE; // see R15
    end else begin
      case (st_q)
        amp_pkg::LNK_ADDR: begin
          shift_q <= {shift_q[6:0], sda_in};        // see R20
          cnt_q   <= cnt_q + 4'h1;
          if (cnt_q == amp_pkg::BIT_LAST) begin
            if (shift_q[6:0] == own_addr_q) begin   // see R17
              st_q <= amp_pkg::LNK_ACK_A;
            end else begin
              st_q <= amp_pkg::LNK_IDLE;            // see R23
            end
          end
        end
        amp_pkg::LNK_ACK_A: begin
          cnt_q      <= 4'h0;
          byte_idx_q <= 1'b0;
          rd_idx_q   <= 2'h0;
          if (shift_q[0]) begin                     // see R22
            st_q     <= amp_pkg::LNK_RD;
            rd_tgl_q <= ~rd_tgl_q;
          end else begin
            st_q <= amp_pkg::LNK_WR;
          end
        end
        amp_pkg::LNK_WR: begin
          shift_q <= {shift_q[6:0], sda_in};
          cnt_q   <= cnt_q + 4'h1;
          if (cnt_q == amp_pkg::BIT_LAST) begin
            st_q <= amp_pkg::LNK_WR_ACK;
            if (!byte_idx_q) begin
              wr_ib1_q <= {shift_q[6:0], sda_in};
            end else begin
              wr_ib2_q <= {shift_q[6:0], sda_in};
              wr_tgl_q <= ~wr_tgl_q;
            end
          end
        end
        amp_pkg::LNK_WR_ACK: begin
          cnt_q      <= 4'h0;
          byte_idx_q <= ~byte_idx_q;
          st_q       <= amp_pkg::LNK_WR;
        end
        amp_pkg::LNK_RD: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == amp_pkg::BIT_LAST) begin
            st_q <= amp_pkg::LNK_RD_ACK;
          end
        end
        amp_pkg::LNK_RD_ACK: begin
          cnt_q <= 4'h0;
          if (sda_in || rd_idx_q == amp_pkg::RD_BYTES_LAST) begin
            st_q <= amp_pkg::LNK_IDLE;              // Host gave no acknowledge, or the fourth byte was sent
          end else begin
            rd_idx_q <= rd_idx_q + 2'h1;
            st_q     <= amp_pkg::LNK_RD;
          end
        end
        default: begin
          st_q <= amp_pkg::LNK_IDLE;
        end
      endcase
    end
  end
  // Current read byte, taken from the held result word
  assign rd_byte = diag_word[amp_pkg::DIAG_W-1 - amp_pkg::BYTE_W * rd_idx_q -: amp_pkg::BYTE_W];
  // Drive data only on the falling clock
  always_ff @(negedge scl_in) begin
    if (!rst_n_in) begin
      sda_oe_n_out <= 1'b1;
    end else begin
      case (st_q)
        amp_pkg::LNK_ACK_A:  sda_oe_n_out <= 1'b0;  // see R21
        amp_pkg::LNK_WR_ACK: sda_oe_n_out <= 1'b0;  // see R21
        amp_pkg::LNK_RD:     sda_oe_n_out <= rd_byte[amp_pkg::BIT_LAST[2:0] - cnt_q[2:0]]; // see R18
        default:             sda_oe_n_out <= 1'b1;
      endcase
    end
  end
  // Crossings from the link into the system clock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_sync_q   <= 2'h0;
      rd_sync_q   <= 2'h0;
      busy_sync_q <= 2'h0;
      sda_out     <= 1'b0;
    end else begin
      wr_sync_q   <= {wr_sync_q[0], wr_tgl_q};
      rd_sync_q   <= {rd_sync_q[0], rd_tgl_q};
      busy_sync_q <= {busy_sync_q[0], start_tgl_q ^ stop_tgl_q};
      sda_out     <= 1'b0;                            // Open drain: only ever pulls low
    end
  end
  // Pin synchronisers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scl_sync_q <= 2'h0;
      sda_sync_q <= 2'h0;
      pin_sync_q <= 2'h0;
      low_sync_q <= 2'h0;
      pw0_sync_q <= 2'h0;
      pw1_sync_q <= 2'h0;
      diag_s1_q  <= '0;
      diag_s2_q  <= '0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      pin_sync_q <= {pin_sync_q[0], standby_mute_pin_in};
      low_sync_q <= {low_sync_q[0], supply_low_in};
      pw0_sync_q <= {pw0_sync_q[0], power_above_in[0]};
      pw1_sync_q <= {pw1_sync_q[0], power_above_in[1]};
      diag_s1_q  <= {thermal_warn_in, fault_in};    // see R5
      diag_s2_q  <= diag_s1_q;
    end
  end
  // Strap pin through two flops, free of reset so it has settled by release
  always_ff @(posedge clk_in) begin
    strap_sync_q <= {strap_sync_q[1:0], address_strap_pin_in};
  end
  // Strap caught once after reset release
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      strap_done_q <= 1'b0;
      bus_en_q     <= 1'b0;
      own_addr_q   <= amp_pkg::ADDR_GND;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      bus_en_q     <= (strap_sync_q[3:2] != amp_pkg::STRAP_OPEN); // see R15
      case (strap_sync_q[3:2])
        amp_pkg::STRAP_MID:  own_addr_q <= amp_pkg::ADDR_MID;  // see R17
        amp_pkg::STRAP_HIGH: own_addr_q <= amp_pkg::ADDR_HIGH; // see R17
        default:             own_addr_q <= amp_pkg::ADDR_GND;  // see R17
      endcase
    end
  end
  // Instruction bytes copied when the second byte lands
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ib1_q     <= amp_pkg::IB1_RESET;
      ib2_q     <= amp_pkg::IB2_RESET;
      wr_seen_q <= 1'b0;
    end else if (wr_sync_q[1] != wr_seen_q) begin
      wr_seen_q <= wr_sync_q[1];
      ib1_q     <= wr_ib1_q;
      ib2_q     <= wr_ib2_q;
    end
  end
  // Read closes the period once the frame has ended
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_seen_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      if (rd_sync_q[1] != rd_seen_q) begin
        rd_seen_q <= rd_sync_q[1];
        rd_pend_q <= 1'b1;
      end else if (read_close) begin
        rd_pend_q <= 1'b0;
      end
    end
  end
  assign read_close = rd_pend_q && !busy_sync_q[1] && (rd_sync_q[1] == rd_seen_q); // see R2
  assign diag_raw   = diag_s2_q;
  diag_hold i_diag_hold (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .close_in   (read_close),
    .fault_in   (diag_raw),
    .result_out (diag_word)
  );
  // Mute request and timer, fast or normal
  assign mute_req = bus_en_q ? !(ib1_q[amp_pkg::IB1_UNMUTE_FR] || ib1_q[amp_pkg::IB1_UNMUTE_RE])
                             : !pin_sync_q[1];
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mute_cnt_q <= '0;
      muted_out  <= 1'b1;
    end else if (!mute_req) begin
      mute_cnt_q <= '0;
      muted_out  <= 1'b0;
    end else if (!muted_out) begin
      mute_cnt_q <= mute_cnt_q + 1'b1;
      if (ib2_q[amp_pkg::IB2_FAST_MUTE]) begin
        muted_out <= (mute_cnt_q >= amp_pkg::MUTE_CNT_W'(FAST_MUTE_CYCLES));   // see R6
      end else begin
        muted_out <= (mute_cnt_q >= amp_pkg::MUTE_CNT_W'(NORMAL_MUTE_CYCLES));
      end
    end
  end
  // Amplifier controls, from bytes or from pins when the bus is off
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      standby_out       <= 1'b1;
      unmute_out        <= 2'h0;
      gain_low_out      <= 2'h0;
      diag_enable_out   <= 1'b0;
      offset_enable_out <= 1'b0;
      bus_disabled_out  <= 1'b0;
    end else if (bus_en_q) begin
      standby_out       <= !ib2_q[amp_pkg::IB2_STANDBY];
      unmute_out        <= {ib1_q[amp_pkg::IB1_UNMUTE_RE], ib1_q[amp_pkg::IB1_UNMUTE_FR]};
      gain_low_out      <= {ib1_q[amp_pkg::IB1_GAIN_RE], ib1_q[amp_pkg::IB1_GAIN_FR]};
      diag_enable_out   <= ib1_q[amp_pkg::IB1_DIAG_EN];
      offset_enable_out <= ib1_q[amp_pkg::IB1_OFFS_EN];
      bus_disabled_out  <= 1'b0;
    end else begin
      standby_out       <= !pin_sync_q[1];           // see R15
      unmute_out        <= {2{pin_sync_q[1]}};
      gain_low_out      <= {2{sda_sync_q[1]}};       // see R16
      diag_enable_out   <= 1'b0;
      offset_enable_out <= 1'b0;
      bus_disabled_out  <= strap_done_q;
    end
  end
  // Bridge switches: pair 0 is channel_one/two, pair 1 is channel_three/four
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bridge_close_out <= 2'h0;
    end else if (low_sync_q[1]) begin
      bridge_close_out <= 2'h0;                     // see R10
    end else if (bus_en_q) begin
      bridge_close_out[0] <= ib2_q[amp_pkg::IB2_HE_LEFT] && !pw0_sync_q[1];  // see R8 R9
      bridge_close_out[1] <= ib2_q[amp_pkg::IB2_HE_RIGHT] && !pw1_sync_q[1]; // see R8 R9
    end else begin
      bridge_close_out[0] <= scl_sync_q[1] && !pw0_sync_q[1];  // see R16
      bridge_close_out[1] <= scl_sync_q[1] && !pw1_sync_q[1];  // see R16
    end
  end
endmodule

// >>> rtl/amp_pkg.sv
package amp_pkg;
  // Bus addresses selected by the strap
  localparam logic [6:0] ADDR_GND   = 7'h6c;
  localparam logic [6:0] ADDR_MID   = 7'h6d;
  localparam logic [6:0] ADDR_HIGH  = 7'h6e;
  // Decoded strap codes
  localparam logic [1:0] STRAP_GND  = 2'h0;
  localparam logic [1:0] STRAP_MID  = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [1:0] STRAP_OPEN = 2'h3;
  // Second instruction byte fields
  localparam int IB2_FAST_MUTE = 5;
  localparam int IB2_STANDBY   = 4;
  localparam int IB2_HE_RIGHT  = 1;
  localparam int IB2_HE_LEFT   = 0;
  // First instruction byte fields
  localparam int IB1_DIAG_EN   = 6;
  localparam int IB1_OFFS_EN   = 5;
  localparam int IB1_GAIN_FR   = 4;
  localparam int IB1_GAIN_RE   = 3;
  localparam int IB1_UNMUTE_FR = 2;
  localparam int IB1_UNMUTE_RE = 1;
  // Reset values of instruction bytes
  localparam logic [7:0] IB1_RESET = 8'h00;
  localparam logic [7:0] IB2_RESET = 8'h00;
  // Diagnostic word layout: thermal warnings in the top bits of the first byte
  localparam int DIAG_W     = 32;
  localparam int FAULT_W    = 29;
  localparam int THERM_LSB  = 29;
  localparam int BYTE_W     = 8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [1:0] RD_BYTES_LAST = 2'h3;
  // Muting times
  localparam int CLK_HZ         = 20_000_000;
  localparam int FAST_MUTE_US   = 1500;
  localparam int FAST_MUTE_CYC  = (FAST_MUTE_US * (CLK_HZ / 1_000_000)) - 1;
  localparam int NORMAL_MUTE_US = 20000;
  localparam int NORMAL_MUTE_CYC = NORMAL_MUTE_US * (CLK_HZ / 1_000_000);
  localparam int MUTE_CNT_W     = 20;
  // Link engine states
  typedef enum logic [6:0] {
    LNK_IDLE   = 7'h01,
    LNK_ADDR   = 7'h02,
    LNK_ACK_A  = 7'h04,
    LNK_WR     = 7'h08,
    LNK_WR_ACK = 7'h10,
    LNK_RD     = 7'h20,
    LNK_RD_ACK = 7'h40
  } link_state_e;
endpackage

// >>> rtl/diag_hold.sv
`timescale 1ns/1ps
// Persistence tracker and result store for the diagnostic word
module diag_hold (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  // Control
  input  wire logic                        close_in,
  input  wire logic [amp_pkg::DIAG_W-1:0]  fault_in,
  // Result of the last closed period
  output logic      [amp_pkg::DIAG_W-1:0]  result_out
);
  logic [amp_pkg::DIAG_W-1:0] persist_q;

  genvar g;
  generate
    for (g = 0; g < amp_pkg::DIAG_W; g++) begin : g_bit
      // A bit survives only while its fault holds every cycle; re-armed on close
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          persist_q[g] <= 1'b1;
        end else if (close_in) begin
          persist_q[g] <= fault_in[g];          // see R2
        end else begin
          persist_q[g] <= persist_q[g] & fault_in[g]; // see R1
        end
      end
      // Published result stays until the next close
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          result_out[g] <= 1'b0;
        end else if (close_in) begin
          result_out[g] <= persist_q[g] & fault_in[g]; // see R3
        end
      end
    end
  endgenerate
endmodule

// >>> tb/amp_port_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the serial port block
module amp_port_assertions (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  // Bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_oe_n_out,
  // Straps and sense inputs
  input wire logic [1:0] address_strap_pin_in,
  input wire logic       standby_mute_pin_in,
  input wire logic [1:0] power_above_in,
  input wire logic       supply_low_in,
  // Controls driven by the block
  input wire logic       standby_out,
  input wire logic [1:0] gain_low_out,
  input wire logic [1:0] bridge_close_out,
  input wire logic       bus_disabled_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Bus off only for the open strap, and then the data line is never pulled
  a_strap_bus_off: assert property (
    $past(rst_n_in, 4) |-> bus_disabled_out == (address_strap_pin_in == amp_pkg::STRAP_OPEN))
    else $error("bus disabled flag wrong for strap");
  a_no_ack_off: assert property (bus_disabled_out |-> sda_oe_n_out)
    else $error("data pulled while bus disabled");
  // Pulled level only moves while the bus clock is low
  a_sda_hold_high: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe_n_out))
    else $error("data changed while clock high");
  // Bridging switches against supply and power demand
  a_supply_low_off: assert property (supply_low_in [*5] |-> bridge_close_out == 2'h0)
    else $error("switch closed at low supply");
  a_pair_lower: assert property (power_above_in[0] [*5] |-> !bridge_close_out[0])
    else $error("first pair switch closed above threshold");
  a_pair_upper: assert property (power_above_in[1] [*5] |-> !bridge_close_out[1])
    else $error("second pair switch closed above threshold");
  // Pin control with the bus disabled
  a_pin_standard_bridge_mode: assert property (
    (bus_disabled_out && !scl_in) [*5] |-> bridge_close_out == 2'h0)
    else $error("switch closed in standard pin mode");
  a_pin_efficiency_mode: assert property (
    (bus_disabled_out && scl_in && !supply_low_in && power_above_in == 2'h0) [*5]
    |-> bridge_close_out == 2'h3)
    else $error("switch open in efficiency pin mode");
  a_pin_gain: assert property (
    (bus_disabled_out && $stable(sda_in)) [*5] |-> gain_low_out == {2{sda_in}})
    else $error("gain does not follow data pin");
  a_pin_standby: assert property (
    (bus_disabled_out && $stable(standby_mute_pin_in)) [*5]
    |-> standby_out == !standby_mute_pin_in)
    else $error("standby does not follow pin");
endmodule

bind amp_control_diag_serial_port amp_port_assertions i_amp_port_assertions (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_oe_n_out(sda_oe_n_out), .address_strap_pin_in(address_strap_pin_in),
  .standby_mute_pin_in(standby_mute_pin_in), .power_above_in(power_above_in),
  .supply_low_in(supply_low_in), .standby_out(standby_out), .gain_low_out(gain_low_out),
  .bridge_close_out(bridge_close_out), .bus_disabled_out(bus_disabled_out));

// >>> tb/host_master.sv
`timescale 1ns/1ps
// Host processor as bus master; clock stands still between frames
module host_master (
  // Bus wires
  output logic       scl_out = 1'b1,
  output logic       sda_pull_out = 1'b0,
  input  wire logic  sda_in,
  // Each ack bit or read byte seen by the host
  output logic [7:0] seen_out = 8'h00,
  output logic       seen_stb_out = 1'b0
);
  localparam int QUARTER = 40;
  // Hand one observation to the bench
  task automatic report(input logic [7:0] v);
    seen_out = v;
    seen_stb_out = ~seen_stb_out;
  endtask
  // Hold both lines at given levels
  task automatic park(input logic c, input logic d);
    scl_out = c;
    sda_pull_out = ~d;
  endtask
  // Clock pulse with data released
  task automatic pulse();
    #QUARTER scl_out = 1'b0;
    #QUARTER scl_out = 1'b1;
  endtask
  // One bit, data set while clock is low
  task automatic bit_cycle(input logic b, output logic r);
    sda_pull_out = ~b;
    #QUARTER scl_out = 1'b1;
    #QUARTER r = sda_in;
    #QUARTER scl_out = 1'b0;
    #QUARTER;
  endtask
  // Start and stop framing
  task automatic start();
    sda_pull_out = 1'b0;
    #QUARTER scl_out = 1'b1;
    #QUARTER sda_pull_out = 1'b1;
    #QUARTER scl_out = 1'b0;
    #QUARTER;
  endtask
  task automatic stop();
    sda_pull_out = 1'b1;
    #QUARTER scl_out = 1'b1;
    #QUARTER sda_pull_out = 1'b0;
    #QUARTER;
  endtask
  // Byte out, MSB first, then the device ack
  task automatic wr(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], r);
    bit_cycle(1'b1, r);
    report({7'h00, r});
  endtask
  // Byte in; host acks all but the last
  task automatic rd(input logic last);
    logic [7:0] v;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      v[i] = r;
    end
    bit_cycle(last, r);
    report(v);
  endtask
endmodule

// >>> tb/test_amp_control_diag_serial_port.sv
`timescale 1ns/1ps
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, g, w); end end
// Self-checking bench for the serial port block
module test_amp_control_diag_serial_port;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [1:0]  strap = 2'h0;
  logic [1:0]  power = 2'h0;
  logic        stby_pin = 1'b0;
  logic        sup_low = 1'b0;
  logic [28:0] fault = 29'h0;
  logic [2:0]  therm = 3'h0;
  logic        scl, host_pull, sda, sda_o, oe_n, stby, diag_en, offs_en, muted, bus_off;
  logic [1:0]  unmute, gain, bridge;
  logic [7:0]  seen, snap = 8'h00;
  logic        seen_stb, snap_stb = 1'b0;
  logic [6:0]  addr;
  logic [6:0]  tab [3] = '{amp_pkg::ADDR_GND, amp_pkg::ADDR_MID, amp_pkg::ADDR_HIGH};
  logic [7:0]  exp_q [$];
  logic [31:0] f, g, p;
  int          bad_count = 0;
  int          checked = 0;
  int          seed = 20911;
  int          n;
  // Clock and open-drain data wire with pull-up
  always #25 clk_in = ~clk_in;
  assign sda = (host_pull || (!oe_n && !sda_o)) ? 1'b0 : 1'b1;
  amp_control_diag_serial_port #(.FAST_MUTE_CYCLES(20), .NORMAL_MUTE_CYCLES(50))
    i_amp_control_diag_serial_port (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_n_out(oe_n), .address_strap_pin_in(strap), .standby_mute_pin_in(stby_pin),
    .fault_in(fault), .thermal_warn_in(therm), .power_above_in(power),
    .supply_low_in(sup_low), .standby_out(stby), .unmute_out(unmute), .gain_low_out(gain),
    .diag_enable_out(diag_en), .offset_enable_out(offs_en), .muted_out(muted),
    .bridge_close_out(bridge), .bus_disabled_out(bus_off));
  host_master i_host_master (.scl_out(scl), .sda_pull_out(host_pull), .sda_in(sda),
    .seen_out(seen), .seen_stb_out(seen_stb));
  // Verdict and end of run
  task automatic stop_test();
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Monitor: oldest note against each observed result
  task automatic take(input logic [7:0] v);
    logic [7:0] w;
    w = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
    `CHK(v, w)
  endtask
  always @(seen_stb) if ($time > 0) take(seen);
  always @(snap_stb) take(snap);
  // Driver helpers
  task automatic clk_wait(input int c);
    repeat (c) @(negedge clk_in);
  endtask
  task automatic check_now(input logic [7:0] v, input logic [7:0] w);
    exp_q.push_back(w);
    #1 snap = v;
    snap_stb = ~snap_stb;
  endtask
  task automatic do_reset(input logic [1:0] s);
    @(negedge clk_in);
    rst_n_in = 1'b0;
    strap = s;
    fork
      i_host_master.pulse();
      clk_wait(6);
    join
    rst_n_in = 1'b1;
    clk_wait(3);
  endtask
  task automatic nack_frame(input logic [6:0] a);
    exp_q.push_back(8'h01);
    i_host_master.start();
    i_host_master.wr({a, 1'b0});
    i_host_master.stop();
  endtask
  task automatic write_frame(input logic [7:0] b1, input logic [7:0] b2);
    repeat (3) exp_q.push_back(8'h00);
    i_host_master.start();
    i_host_master.wr({addr, 1'b0});
    i_host_master.wr(b1);
    i_host_master.wr(b2);
    i_host_master.stop();
  endtask
  task automatic read_frame(input logic [31:0] w);
    exp_q.push_back(8'h00);
    for (int k = 3; k >= 0; k--) exp_q.push_back(w[8*k +: 8]);
    i_host_master.start();
    i_host_master.wr({addr, 1'b1});
    for (int k = 3; k >= 0; k--) i_host_master.rd(k == 0);
    i_host_master.stop();
    clk_wait(5);
  endtask
  // Main sequence
  initial begin
    for (int s = 0; s < 3; s++) begin
      do_reset(2'(s));
      nack_frame(tab[(s + 1) % 3]);
      addr = tab[s];
      write_frame(8'h46, 8'h13);
      clk_wait(8);
      check_now({1'b0, stby, unmute, diag_en, offs_en, bridge}, 8'h3b);
    end
    repeat (6) begin
      clk_wait(1);
      p = $random(seed);
      power = p[1:0];
      sup_low = p[2];
      clk_wait(5);
      check_now({6'h00, bridge}, {6'h00, (p[2] ? 2'h0 : ~p[1:0])});
    end
    power = 2'h0;
    sup_low = 1'b0;
    for (int m = 1; m >= 0; m--) begin
      write_frame(8'h46, 8'h13);
      clk_wait(80);
      check_now({7'h00, muted}, 8'h00);
      write_frame(8'h40, {2'h0, m[0], 5'h13});
      n = 0;
      while (muted !== 1'b1 && n < 200) begin
        clk_wait(1);
        n++;
      end
      check_now({7'h00, n < 35}, {7'h00, m[0]});
    end
    do_reset(2'h0);
    addr = tab[0];
    f = $random(seed);
    g = $random(seed);
    fault = f[28:0];
    therm = f[31:29];
    read_frame(32'h0);
    read_frame(32'h0);
    fault = f[28:0] & ~g[28:0];
    clk_wait(4);
    fault = f[28:0];
    read_frame(f);
    read_frame({f[31:29], f[28:0] & ~g[28:0]});
    do_reset(2'h3);
    check_now({7'h00, bus_off}, 8'h01);
    nack_frame(tab[0]);
    repeat (6) begin
      clk_wait(1);
      p = $random(seed);
      i_host_master.park(p[0], p[1]);
      stby_pin = p[2];
      clk_wait(6);
      check_now({3'h0, stby, gain, bridge}, {3'h0, ~p[2], {2{p[1]}}, {2{p[0]}}});
    end
    stop_test();
  end
  // Watchdog
  initial begin
    #2_000_000;
    bad_count++;
    stop_test();
  end
endmodule
